// ==== include/scmc_pkg.sv ====
// shared constants and types of the system clock and mode controller
package scmc_pkg;

  // clock rates in Hz
  localparam int unsigned CLK_HZ           = 32'h017D_7840; // 25 MHz aclk
  localparam int unsigned FAST_OSC_HZ      = 32'h003D_0900; // 4 MHz
  localparam int unsigned SLOW_OSC_HZ      = 32'h0000_7D00; // 32 kHz
  localparam int unsigned FAST_READY_TICKS = 32'h0000_0010; // 16 oscillator cycles
  localparam int unsigned SLOW_READY_TICKS = 32'h0000_0002; // 2 oscillator cycles

  // register byte addresses
  localparam int unsigned ADDR_W           = 8;
  localparam logic [7:0]  ADDR_CLOCK_MODE  = 8'h00;
  localparam logic [7:0]  ADDR_IDLE_CTRL   = 8'h04;
  localparam logic [7:0]  ADDR_POWER_CTRL  = 8'h08;
  localparam logic [7:0]  ADDR_MODE_STATUS = 8'h0C;

  // field positions
  localparam int unsigned CM_DIV_LSB       = 5;
  localparam int unsigned CM_SLOW_RDY      = 3;
  localparam int unsigned CM_FAST_RDY      = 2;
  localparam int unsigned CM_IDLE_EN       = 1;
  localparam int unsigned CM_FAST_SLOW     = 0;
  localparam int unsigned IC_SYSCLK_KEEP   = 7;
  localparam int unsigned PC_LVD_EN        = 0;
  localparam int unsigned PC_WDT_EN        = 1;
  localparam int unsigned MS_MODE_LSB      = 0;
  localparam int unsigned MS_SWITCH_PEND   = 3;
  localparam int unsigned MS_ACT_FAST      = 4;

  // reset values
  localparam logic [2:0]  DIV_SEL_RST      = 3'h6;
  localparam logic        FAST_SLOW_RST    = 1'h0;
  localparam logic        IDLE_EN_RST      = 1'h1;
  localparam logic        SYSCLK_KEEP_RST  = 1'h0;
  localparam logic        LVD_EN_RST       = 1'h0;
  localparam logic        WDT_EN_RST       = 1'h0;

  // divider decode: codes up to this one pick the sub clock
  localparam logic [2:0]  DIV_SUB_MAX      = 3'h1;
  localparam logic [3:0]  DIV_LOG_BASE     = 4'h8;

  // mode codes as software reads them
  localparam logic [2:0]  MODE_NORMAL      = 3'h0;
  localparam logic [2:0]  MODE_SLOW        = 3'h1;
  localparam logic [2:0]  MODE_IDLE0       = 3'h2;
  localparam logic [2:0]  MODE_IDLE1       = 3'h3;
  localparam logic [2:0]  MODE_SLEEP0      = 3'h4;
  localparam logic [2:0]  MODE_SLEEP1      = 3'h5;

  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN    = 3'h0,
    ST_IDLE1  = 3'h1,
    ST_IDLE0  = 3'h3,
    ST_SLEEP1 = 3'h2,
    ST_SLEEP0 = 3'h6
  } scmc_state_t;

  // clock enables and oscillator controls toward the rest of the chip
  typedef struct packed {
    logic cpu_clk_en;
    logic sys_clk_en;
    logic sub_clk_en;
    logic timebase_clk_en;
    logic wdt_clk_en;
    logic fast_rc_osc_on;
    logic slow_rc_osc_on;
    logic lvd_bandgap_keep;
  } scmc_clk_out_t;

endpackage

// ==== hw/scmc_rc_osc.sv ====
// behavioural RC oscillator: tick enable and start-up ready flag
`timescale 1ns/10ps
`default_nettype none
module scmc_rc_osc #(
  parameter int unsigned CLK_HZ      = 32'h017D_7840,
  parameter int unsigned OSC_HZ      = 32'h003D_0900,
  parameter int unsigned READY_TICKS = 32'h0000_0010
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // control
  input  wire logic run,
  // oscillator outputs
  output logic      tick,
  output logic      ready
);

  typedef struct packed {
    logic [31:0] acc;
    logic [7:0]  cnt;
    logic        tick;
    logic        ready;
  } scmc_osc_state_t;

  localparam scmc_osc_state_t OSC_RST = '0;
  localparam logic [7:0] READY_LAST = 8'(READY_TICKS - 1);

  scmc_osc_state_t s_q;
  scmc_osc_state_t s_d;
  logic [31:0]     acc_sum;

  // phase accumulator keeps the average rate exact on a 25 MHz clock
  always_comb begin
    s_d      = s_q;
    acc_sum  = s_q.acc + OSC_HZ;
    s_d.tick = 1'h0;
    if (!run) begin
      // stopped oscillator loses its stable state
      s_d = OSC_RST;
    end else if (acc_sum >= CLK_HZ) begin
      s_d.acc  = acc_sum - CLK_HZ;
      s_d.tick = 1'h1;
      if (s_q.cnt == READY_LAST) begin
        s_d.ready = 1'h1;
      end else if (!s_q.ready) begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
    end else begin
      s_d.acc = acc_sum;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= OSC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick  = s_q.tick;
  assign ready = s_q.ready;

endmodule
`default_nettype wire

// ==== hw/scmc_top.sv ====
// system clock source selection and operating mode sequencer with AXI4-Lite registers
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module scmc_top (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite write address
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [scmc_pkg::ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  // AXI4-Lite write response
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output logic [1:0]                       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  input  wire logic [scmc_pkg::ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  // CPU core events
  input  wire logic                        halt_req,
  input  wire logic                        wake_req,
  // clock enables and oscillator controls
  output scmc_pkg::scmc_clk_out_t          clk_out
);

  typedef struct packed {
    scmc_pkg::scmc_state_t   st;
    logic [2:0]              clock_divider_select;
    logic                    fast_slow_select;
    logic                    idle_mode_enable;
    logic                    idle_sysclk_keep;
    logic                    lowvolt_detect_enable;
    logic                    wdt_enable;
    logic                    lvd_latched;
    logic                    act_fast;
    logic [2:0]              act_log;
    logic [5:0]              div_cnt;
    logic                    aw_have;
    logic [7:0]              aw_addr;
    logic                    w_have;
    logic [7:0]              w_data;
    logic                    w_stb;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [7:0]              rdata;
    logic [1:0]              rresp;
    scmc_pkg::scmc_clk_out_t clk;
  } scmc_top_state_t;

  localparam scmc_top_state_t TOP_RST = '{
    st:                    scmc_pkg::ST_RUN,
    clock_divider_select:  scmc_pkg::DIV_SEL_RST,
    fast_slow_select:      scmc_pkg::FAST_SLOW_RST,
    idle_mode_enable:      scmc_pkg::IDLE_EN_RST,
    idle_sysclk_keep:      scmc_pkg::SYSCLK_KEEP_RST,
    lowvolt_detect_enable: scmc_pkg::LVD_EN_RST,
    wdt_enable:            scmc_pkg::WDT_EN_RST,
    lvd_latched:           1'h0,
    act_fast:              1'h1,
    act_log:               3'h2,
    div_cnt:               6'h00,
    aw_have:               1'h0,
    aw_addr:               8'h00,
    w_have:                1'h0,
    w_data:                8'h00,
    w_stb:                 1'h0,
    awready:               1'h0,
    wready:                1'h0,
    bvalid:                1'h0,
    bresp:                 2'h0,
    arready:               1'h0,
    rvalid:                1'h0,
    rdata:                 8'h00,
    rresp:                 2'h0,
    clk:                   '0
  };

  scmc_top_state_t s_q;
  scmc_top_state_t s_d;

  logic       fast_tick;
  logic       fast_ready;
  logic       slow_tick;
  logic       slow_ready;
  logic       req_fast;
  logic [2:0] req_log;
  logic [3:0] log_diff;
  logic       pending;
  logic       tgt_ready;
  logic [5:0] ratio_m1;
  logic       div_done;
  logic       src_tick;
  logic       src_ready;
  logic       sys_tick;
  logic       do_switch;
  logic [2:0] mode_code;
  logic [7:0] rd_val;
  logic       rd_ok;
  logic       is_run;
  logic       is_idle1;

  // fast oscillator, started only while some clock needs it
  scmc_rc_osc #(
    .CLK_HZ      (scmc_pkg::CLK_HZ),
    .OSC_HZ      (scmc_pkg::FAST_OSC_HZ),
    .READY_TICKS (scmc_pkg::FAST_READY_TICKS)
  ) u_fast_osc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (s_q.clk.fast_rc_osc_on),
    .tick    (fast_tick),
    .ready   (fast_ready)
  );

  // sub oscillator
  scmc_rc_osc #(
    .CLK_HZ      (scmc_pkg::CLK_HZ),
    .OSC_HZ      (scmc_pkg::SLOW_OSC_HZ),
    .READY_TICKS (scmc_pkg::SLOW_READY_TICKS)
  ) u_slow_osc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (s_q.clk.slow_rc_osc_on),
    .tick    (slow_tick),
    .ready   (slow_ready)
  );

  always_comb begin
    s_d = s_q;

    is_run   = (s_q.st == scmc_pkg::ST_RUN);
    is_idle1 = (s_q.st == scmc_pkg::ST_IDLE1);

    // requested source: one of fast or sub, never neither
    req_fast = s_q.fast_slow_select
               || (s_q.clock_divider_select > scmc_pkg::DIV_SUB_MAX);
    log_diff = scmc_pkg::DIV_LOG_BASE - {1'h0, s_q.clock_divider_select};
    req_log  = s_q.fast_slow_select ? 3'h0 : log_diff[2:0];

    // active divider on the fast source, ratio 2**act_log; the sub clock is not divided
    ratio_m1  = 6'((7'h01 << s_q.act_log) - 7'h01);
    div_done  = (s_q.div_cnt == ratio_m1);
    src_tick  = s_q.act_fast ? (fast_tick && div_done) : slow_tick;
    src_ready = s_q.act_fast ? fast_ready : slow_ready;
    sys_tick  = src_tick && src_ready;

    if (s_q.act_fast && fast_tick) begin
      s_d.div_cnt = div_done ? 6'h00 : s_q.div_cnt + 6'h01;
    end

    // source change: only when the old period has just closed, or the old
    // source is not ticking, so no shortened pulse reaches the consumers
    pending   = (req_fast != s_q.act_fast) || (req_fast && (req_log != s_q.act_log));
    tgt_ready = req_fast ? fast_ready : slow_ready;
    do_switch = is_run && pending && tgt_ready && (src_tick || !src_ready);
    if (do_switch) begin
      s_d.act_fast = req_fast;
      s_d.act_log  = req_log;
      s_d.div_cnt  = 6'h00;
    end

    // mode sequencing
    unique case (s_q.st)
      scmc_pkg::ST_RUN: begin
        if (halt_req) begin
          s_d.lvd_latched = s_q.lowvolt_detect_enable;
          if (s_q.idle_mode_enable) begin
            s_d.st = s_q.idle_sysclk_keep ? scmc_pkg::ST_IDLE1
                                          : scmc_pkg::ST_IDLE0;
          end else if (s_q.lowvolt_detect_enable || s_q.wdt_enable) begin
            s_d.st = scmc_pkg::ST_SLEEP1;
          end else begin
            s_d.st = scmc_pkg::ST_SLEEP0;
          end
        end
      end
      scmc_pkg::ST_IDLE0, scmc_pkg::ST_IDLE1,
      scmc_pkg::ST_SLEEP0, scmc_pkg::ST_SLEEP1: begin
        if (wake_req) begin
          s_d.st = scmc_pkg::ST_RUN;
        end
      end
      default: begin
        s_d.st = scmc_pkg::ST_RUN;
      end
    endcase

    // clock enables, registered one cycle behind the oscillator tick
    s_d.clk.cpu_clk_en      = sys_tick && is_run;
    s_d.clk.sys_clk_en      = sys_tick && (is_run || is_idle1);
    s_d.clk.timebase_clk_en = slow_tick
                              && (s_q.st != scmc_pkg::ST_SLEEP0)
                              && (s_q.st != scmc_pkg::ST_SLEEP1);
    s_d.clk.wdt_clk_en      = slow_tick && s_q.wdt_enable
                              && (s_q.st != scmc_pkg::ST_SLEEP0);
    // fast oscillator off once neither the active nor the requested
    // source needs it; consumers of divided fast clocks lose them too
    s_d.clk.fast_rc_osc_on  = (is_run && (s_q.act_fast || req_fast))
                              || (is_idle1 && s_q.act_fast);
    s_d.clk.slow_rc_osc_on  = !((s_q.st == scmc_pkg::ST_SLEEP0)
                                && !s_q.lvd_latched);
    // a tick already in flight must not outlive the stopped oscillator
    s_d.clk.sub_clk_en      = slow_tick && s_d.clk.slow_rc_osc_on;
    s_d.clk.lvd_bandgap_keep = is_run ? s_q.lowvolt_detect_enable
                                      : s_q.lvd_latched;

    // mode as software sees it
    unique case (s_q.st)
      scmc_pkg::ST_RUN:    mode_code = s_q.act_fast ? scmc_pkg::MODE_NORMAL
                                                    : scmc_pkg::MODE_SLOW;
      scmc_pkg::ST_IDLE0:  mode_code = scmc_pkg::MODE_IDLE0;
      scmc_pkg::ST_IDLE1:  mode_code = scmc_pkg::MODE_IDLE1;
      scmc_pkg::ST_SLEEP0: mode_code = scmc_pkg::MODE_SLEEP0;
      scmc_pkg::ST_SLEEP1: mode_code = scmc_pkg::MODE_SLEEP1;
      default:             mode_code = scmc_pkg::MODE_NORMAL;
    endcase

    // AXI4-Lite write: address and data are taken in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'h1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'h1;
      s_d.w_data = s_axi_wdata[7:0];
      s_d.w_stb  = s_axi_wstrb[0];
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'h0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'h0;
      s_d.w_have  = 1'h0;
      s_d.bvalid  = 1'h1;
      s_d.bresp   = scmc_pkg::RESP_OKAY;
      unique case (s_q.aw_addr)
        scmc_pkg::ADDR_CLOCK_MODE: begin
          if (s_q.w_stb) begin
            s_d.clock_divider_select = s_q.w_data[scmc_pkg::CM_DIV_LSB +: 3];
            s_d.idle_mode_enable     = s_q.w_data[scmc_pkg::CM_IDLE_EN];
            s_d.fast_slow_select     = s_q.w_data[scmc_pkg::CM_FAST_SLOW];
          end
        end
        scmc_pkg::ADDR_IDLE_CTRL: begin
          if (s_q.w_stb) begin
            s_d.idle_sysclk_keep = s_q.w_data[scmc_pkg::IC_SYSCLK_KEEP];
          end
        end
        scmc_pkg::ADDR_POWER_CTRL: begin
          if (s_q.w_stb) begin
            s_d.lowvolt_detect_enable = s_q.w_data[scmc_pkg::PC_LVD_EN];
            s_d.wdt_enable            = s_q.w_data[scmc_pkg::PC_WDT_EN];
          end
        end
        scmc_pkg::ADDR_MODE_STATUS: begin
          // read only, write ignored
        end
        default: begin
          s_d.bresp = scmc_pkg::RESP_SLVERR;
        end
      endcase
    end
    // hold each channel closed while its item or the response is waiting
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;

    // AXI4-Lite read
    rd_val = 8'h00;
    rd_ok  = 1'h1;
    unique case (s_axi_araddr)
      scmc_pkg::ADDR_CLOCK_MODE: begin
        rd_val[scmc_pkg::CM_DIV_LSB +: 3]   = s_q.clock_divider_select;
        rd_val[scmc_pkg::CM_SLOW_RDY]       = slow_ready;
        rd_val[scmc_pkg::CM_FAST_RDY]       = fast_ready;
        rd_val[scmc_pkg::CM_IDLE_EN]        = s_q.idle_mode_enable;
        rd_val[scmc_pkg::CM_FAST_SLOW]      = s_q.fast_slow_select;
      end
      scmc_pkg::ADDR_IDLE_CTRL: begin
        rd_val[scmc_pkg::IC_SYSCLK_KEEP]    = s_q.idle_sysclk_keep;
      end
      scmc_pkg::ADDR_POWER_CTRL: begin
        rd_val[scmc_pkg::PC_LVD_EN]         = s_q.lowvolt_detect_enable;
        rd_val[scmc_pkg::PC_WDT_EN]         = s_q.wdt_enable;
      end
      scmc_pkg::ADDR_MODE_STATUS: begin
        rd_val[scmc_pkg::MS_MODE_LSB +: 3]  = mode_code;
        rd_val[scmc_pkg::MS_SWITCH_PEND]    = pending;
        rd_val[scmc_pkg::MS_ACT_FAST]       = s_q.act_fast;
      end
      default: begin
        rd_ok = 1'h0;
      end
    endcase
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'h0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'h1;
      s_d.rdata  = rd_val;
      s_d.rresp  = rd_ok ? scmc_pkg::RESP_OKAY : scmc_pkg::RESP_SLVERR;
    end
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= TOP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = {24'h00_0000, s_q.rdata};
  assign s_axi_rresp   = s_q.rresp;
  assign clk_out       = s_q.clk;

endmodule
`default_nettype wire

// ==== tb/scmc_monitor.sv ====
// port-level assertions for the clock and mode controller
`timescale 1ns/10ps
`default_nettype none
module scmc_monitor (
  // clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // read channel
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic [31:0]             s_axi_rdata,
  // core events and clock controls
  input wire logic                    halt_req,
  input wire scmc_pkg::scmc_clk_out_t clk_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  osc_after_reset_a: assert property ($rose(aresetn) |=> clk_out.fast_rc_osc_on && clk_out.slow_rc_osc_on)
    else $error("oscillators not started after reset");
  cpu_halt_off_a: assert property (halt_req |-> ##3 !clk_out.cpu_clk_en [*8])
    else $error("cpu clock still running after halt");
  cpu_in_sys_a: assert property (clk_out.cpu_clk_en |-> clk_out.sys_clk_en)
    else $error("cpu pulse without system pulse");
  sub_tick_gap_a: assert property (clk_out.sub_clk_en |=> !clk_out.sub_clk_en [*8])
    else $error("sub clock ticks too close");
  sub_needs_osc_a: assert property (clk_out.sub_clk_en |-> clk_out.slow_rc_osc_on)
    else $error("sub tick with sub oscillator off");
  tbc_from_sub_a: assert property (clk_out.timebase_clk_en |-> clk_out.sub_clk_en)
    else $error("time base pulse without sub tick");
  wdt_from_sub_a: assert property (clk_out.wdt_clk_en |-> clk_out.sub_clk_en)
    else $error("watchdog pulse without sub tick");
  lvd_sub_on_a: assert property (clk_out.lvd_bandgap_keep |-> clk_out.slow_rc_osc_on)
    else $error("detector kept but sub oscillator off");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before ready");

  cover property (halt_req);
  cover property (clk_out.lvd_bandgap_keep && !clk_out.cpu_clk_en);
  cover property (s_axi_rvalid && !s_axi_rready);
endmodule
`default_nettype wire

// ==== tb/scmc_cpu_model.sv ====
// core model: register accesses over AXI4-Lite and halt or wake pulses
`timescale 1ns/10ps
`default_nettype none
module scmc_cpu_model (
  // clock
  input  wire logic        aclk,
  // write side
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  // read side
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic [7:0]       s_axi_araddr,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  // core events
  output logic             halt_req,
  output logic             wake_req
);
  initial {s_axi_awvalid, s_axi_awaddr, s_axi_wvalid, s_axi_wdata, s_axi_wstrb, s_axi_bready,
           s_axi_arvalid, s_axi_araddr, s_axi_rready, halt_req, wake_req} = '0;

  // released payload is inverted so a stale value is never mistaken for a fresh one
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_wstrb   <= 4'hF;
    s_axi_bready  <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~{24'h00_0000, d};
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // ready raised late on purpose so the slave must hold its answer
  task automatic axi_rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr  <= ~a;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic pulse(input logic halt);
    @(posedge aclk);
    halt_req <= halt;
    wake_req <= !halt;
    @(posedge aclk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/scmc_tb.sv ====
// self-checking bench of the clock and mode controller
`timescale 1ns/10ps
`default_nettype none
module scmc_tb;
  logic                    aclk;
  logic                    aresetn;
  logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                    s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                    s_axi_rvalid, s_axi_rready, halt_req, wake_req;
  logic [7:0]              s_axi_awaddr, s_axi_araddr, rd;
  logic [31:0]             s_axi_wdata, s_axi_rdata;
  logic [3:0]              s_axi_wstrb;
  logic [1:0]              s_axi_bresp, s_axi_rresp, rs;
  scmc_pkg::scmc_clk_out_t clk_out;
  int                      err_total = 0;
  int                      num_checks = 0;
  int                      cyc = 0;

  scmc_top i_scmc_top (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .halt_req, .wake_req, .clk_out);
  scmc_cpu_model i_scmc_cpu_model (.aclk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .halt_req, .wake_req);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // whole run is about 40k cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      $display("MISMATCH %0t timeout", $time);
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int exp);
    num_checks++;
    if (got < exp - 3 || got > exp + 3) begin
      err_total++;
      $display("MISMATCH %0t period %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_scmc_cpu_model.axi_wr(a, d, rs);
    chk({6'h00, rs}, {6'h00, scmc_pkg::RESP_OKAY});
  endtask

  task automatic rdr(input logic [7:0] a);
    i_scmc_cpu_model.axi_rd(a, rd, rs);
  endtask

  // cycles spanned by four system clock periods, after the switch has settled
  task automatic period(output int n);
    int t0;
    repeat (3) do @(posedge aclk); while (clk_out.sys_clk_en !== 1'b1);
    t0 = cyc;
    repeat (4) do @(posedge aclk); while (clk_out.cpu_clk_en !== 1'b1);
    n = cyc - t0;
  endtask

  task automatic t_reset();
    repeat (2000) @(posedge aclk);
    chk({6'h00, clk_out.fast_rc_osc_on, clk_out.slow_rc_osc_on}, 8'h03);
    wr(scmc_pkg::ADDR_CLOCK_MODE, 8'hC2);
    rdr(scmc_pkg::ADDR_CLOCK_MODE);
    chk(rd, 8'hCE);
    rdr(scmc_pkg::ADDR_IDLE_CTRL);
    chk(rd, 8'h00);
    rdr(scmc_pkg::ADDR_POWER_CTRL);
    chk(rd, 8'h00);
    rdr(scmc_pkg::ADDR_MODE_STATUS);
    chk(rd, 8'h10);
    rdr(8'h10);
    chk({6'h00, rs}, {6'h00, scmc_pkg::RESP_SLVERR});
    i_scmc_cpu_model.axi_wr(8'h10, 8'hFF, rs);
    chk({6'h00, rs}, {6'h00, scmc_pkg::RESP_SLVERR});
  endtask

  task automatic t_divider();
    int n;
    int exp;
    logic [2:0] code;
    logic fs;
    logic slow;
    for (int i = 0; i < 9; i++) begin
      code = i[2:0];
      fs = (i == 8);
      slow = !fs && code <= scmc_pkg::DIV_SUB_MAX;
      wr(scmc_pkg::ADDR_CLOCK_MODE, {code, 3'h0, 1'b1, fs});
      period(n);
      exp = fs ? 25 : slow ? 3125 : 25 << (8 - code);
      chk_rng(n, exp);
      rdr(scmc_pkg::ADDR_MODE_STATUS);
      chk({2'h0, clk_out.fast_rc_osc_on, rd[4:0]}, {2'h0, !slow, !slow, 1'b0,
          slow ? scmc_pkg::MODE_SLOW : scmc_pkg::MODE_NORMAL});
    end
  endtask

  // cfg: idle en, keep, detect, watchdog; seen: wdt, cpu, sys, sub, tbc, keep, fast/slow ready
  task automatic t_halt(input logic [3:0] cfg, input logic [2:0] mode, input logic [7:0] exp);
    logic [7:0] seen;
    wr(scmc_pkg::ADDR_CLOCK_MODE, {3'h6, 3'h0, cfg[3], 1'b0});
    wr(scmc_pkg::ADDR_IDLE_CTRL, {cfg[2], 7'h00});
    wr(scmc_pkg::ADDR_POWER_CTRL, {6'h00, cfg[0], cfg[1]});
    i_scmc_cpu_model.pulse(1'b1);
    seen = '0;
    repeat (4) @(posedge aclk);
    repeat (1700) begin
      @(posedge aclk);
      seen |= {clk_out.wdt_clk_en, clk_out.cpu_clk_en, clk_out.sys_clk_en, clk_out.sub_clk_en,
               clk_out.timebase_clk_en, clk_out.lvd_bandgap_keep, 2'b00};
    end
    rdr(scmc_pkg::ADDR_CLOCK_MODE);
    seen[1:0] = {rd[scmc_pkg::CM_FAST_RDY], rd[scmc_pkg::CM_SLOW_RDY]};
    chk(seen, exp);
    rdr(scmc_pkg::ADDR_MODE_STATUS);
    chk({5'h00, rd[2:0]}, {5'h00, mode});
    i_scmc_cpu_model.pulse(1'b0);
    repeat (2000) @(posedge aclk);
    rdr(scmc_pkg::ADDR_MODE_STATUS);
    chk({5'h00, rd[2:0]}, {5'h00, scmc_pkg::MODE_NORMAL});
  endtask

  initial begin
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_divider();
    t_halt(4'b0000, scmc_pkg::MODE_SLEEP0, 8'b00000000);
    t_halt(4'b0001, scmc_pkg::MODE_SLEEP1, 8'b10010001);
    t_halt(4'b0010, scmc_pkg::MODE_SLEEP1, 8'b00010101);
    t_halt(4'b1000, scmc_pkg::MODE_IDLE0, 8'b00011001);
    t_halt(4'b1100, scmc_pkg::MODE_IDLE1, 8'b00111011);
    t_halt(4'b1010, scmc_pkg::MODE_IDLE0, 8'b00011101);
    finish_test();
  end
endmodule

bind scmc_top scmc_monitor i_scmc_monitor (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .halt_req, .clk_out);
`default_nettype wire
